/* rtl/pioep_params.svh */
// Constants of the parallel input/output event port: register byte offsets,
// field positions, reset values and timing figures.
// Assumes it is included by bare name from the design files, after the package.
`ifndef PIOEP_PARAMS_SVH
`define PIOEP_PARAMS_SVH

`define PIOEP_ADDR_IN_LEVEL 8'h00
`define PIOEP_ADDR_IN_SEL 8'h04
`define PIOEP_ADDR_IN_RESULT 8'h08
`define PIOEP_ADDR_OUT_CMD 8'h0C
`define PIOEP_ADDR_OUT_DELAY 8'h10
`define PIOEP_ADDR_OUT_LEVEL 8'h14
`define PIOEP_ADDR_TRIG_CTRL 8'h18
`define PIOEP_ADDR_STATUS 8'h1C
`define PIOEP_ADDR_MASK 8'h20
`define PIOEP_ADDR_EVT_LATCH0 8'h24
`define PIOEP_ADDR_EVT_LATCH1 8'h28
`define PIOEP_ADDR_EVT_LATCH2 8'h2C
`define PIOEP_ADDR_EVT_LATCH3 8'h30

`define PIOEP_TRIG_ARM_BIT 0
`define PIOEP_TRIG_DISARM_BIT 1
`define PIOEP_STAT_TRIG_BIT 0
`define PIOEP_STAT_EDGE_LSB 1

`define PIOEP_IN_LINES 5
`define PIOEP_OUT_LINES 12
`define PIOEP_EDGE_LINES 3
`define PIOEP_DELAY_W 16

`define PIOEP_OUT_RESET 12'h000
`define PIOEP_MASK_RESET 4'h0
`define PIOEP_DELAY_RESET 16'h0000
`define PIOEP_IN_SEL_RESET 32'h00000000

`define PIOEP_CLK_PERIOD_NS 4
`define PIOEP_SECOND_NS 1000000000

`endif

/* rtl/pioep_pkg.sv */
// Types of the parallel input/output event port.
// Assumes the register layouts fixed by pioep_params.svh.
package pioep_pkg;

    typedef enum logic [1:0] {
        PIOEP_SINGLE_READ = 2'b00,
        PIOEP_RANGE_READ = 2'b01,
        PIOEP_MASKED_INPUT_READ = 2'b10
    } pioep_in_mode_type;

    typedef enum logic [1:0] {
        PIOEP_TRIG_IDLE = 2'b00,
        PIOEP_TRIG_ARMED = 2'b01,
        PIOEP_TRIG_FIRED = 2'b10
    } pioep_trig_state_type;

    typedef struct packed {
        logic [13:0] rsv_hi;
        pioep_in_mode_type mode;
        logic rsv_last;
        logic [2:0] last;
        logic rsv_first;
        logic [2:0] first;
        logic [2:0] rsv_mask;
        logic [4:0] mask;
    } pioep_in_sel_type;

    typedef struct packed {
        logic [7:0] rsv_hi;
        logic [3:0] last;
        logic [3:0] first;
        logic [1:0] rsv_mid;
        logic range_sel;
        logic state;
        logic [11:0] mask;
    } pioep_out_cmd_type;

endpackage

/* rtl/pioep_sync.sv */
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the pins are quasi-static per bit; only the second stage is exported.
`timescale 1ns/1ns
`default_nettype none

module pioep_sync #(
    parameter int WIDTH = 8
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1_reg <= '0;
            sync_out <= '0;
        end else if (ce) begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule

`default_nettype wire

/* rtl/pioep_top.sv */
// Parallel input/output event port with an AHB-Lite register slave.
// Assumes one clock, pins asynchronous to it, and an always-OKAY single-word bus master.
`timescale 1ns/1ns
`default_nettype none
`include "pioep_params.svh"

module pioep_top
    import pioep_pkg::*;
#(
    parameter logic [31:0] TICK_CYCLES = 32'(`PIOEP_SECOND_NS / `PIOEP_CLK_PERIOD_NS),
    parameter int DELAY_W = `PIOEP_DELAY_W
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic [`PIOEP_IN_LINES-1:0] in_line_pin,
    input wire logic [`PIOEP_EDGE_LINES-1:0] ext_transition_pin,
    output logic [`PIOEP_OUT_LINES-1:0] out_line,
    output logic irq
);

    localparam int NIN = `PIOEP_IN_LINES;
    localparam int NOUT = `PIOEP_OUT_LINES;
    localparam int NEDGE = `PIOEP_EDGE_LINES;
    localparam int NEVT = NEDGE + 1;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // Lines are numbered from one; bit i covers line i+1.
    function automatic logic [11:0] pioep_span(input logic [3:0] first, input logic [3:0] last);
        logic [11:0] span;
        span = 12'h000;
        for (int i = 0; i < 12; i++) begin
            span[i] = (5'(i + 1) >= {1'b0, first}) && (5'(i + 1) <= {1'b0, last});
        end
        return span;
    endfunction

    // Synchronised pins.
    logic [NIN+NEDGE-1:0] sync_w;
    logic [NIN-1:0] in_snap_reg;
    logic [NEDGE-1:0] edge_prev_reg;
    wire logic [NIN-1:0] in_sync_w = sync_w[NIN-1:0];
    wire logic [NEDGE-1:0] edge_sync_w = sync_w[NIN+NEDGE-1:NIN];

    pioep_sync #(
        .WIDTH(NIN + NEDGE)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .async_in({ext_transition_pin, in_line_pin}),
        .sync_out(sync_w)
    );

    // Bus state and registers.
    logic wr_pend_reg;
    logic [7:0] wr_addr_reg;
    pioep_in_sel_type in_sel_reg;
    logic [DELAY_W-1:0] out_delay_reg;
    logic [NEVT-1:0] status_reg;
    logic [NEVT-1:0] mask_reg;
    logic [31:0] presc_reg;
    logic [DELAY_W-1:0] timer_reg [NOUT];
    logic [NIN-1:0] latch_reg [NEVT];
    pioep_trig_state_type trig_reg;
    pioep_trig_state_type trig_next;

    // Address phase decode; only writes must be word-wide, reads of any size are taken, upper address bits alias.
    wire logic addr_ok_w = hsel && htrans[1] && hready;
    wire logic wr_take_w = addr_ok_w && hwrite && (hsize == 3'h2);
    wire logic rd_take_w = addr_ok_w && !hwrite;
    wire logic [7:0] rd_addr_w = {haddr[7:2], 2'h0};

    // Data phase write strobes.
    wire logic wr_in_sel_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_IN_SEL);
    wire logic out_wr_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_OUT_CMD);
    wire logic wr_delay_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_OUT_DELAY);
    wire logic wr_trig_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_TRIG_CTRL);
    wire logic wr_status_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_STATUS);
    wire logic wr_mask_w = wr_pend_reg && (wr_addr_reg == `PIOEP_ADDR_MASK);
    wire logic arm_user_trigger = wr_trig_w && hwdata[`PIOEP_TRIG_ARM_BIT];
    wire logic disarm_user_trigger = wr_trig_w && hwdata[`PIOEP_TRIG_DISARM_BIT];

    // Input reads all work on the one snapshot register.
    wire logic [11:0] in_range_w = pioep_span({1'b0, in_sel_reg.first}, {1'b0, in_sel_reg.last});
    wire logic [11:0] in_one_w = pioep_span({1'b0, in_sel_reg.first}, {1'b0, in_sel_reg.first});
    wire logic single_w = |(in_snap_reg & in_one_w[NIN-1:0]);
    wire logic [NIN-1:0] range_w = in_snap_reg & in_range_w[NIN-1:0];
    wire logic [NIN-1:0] masked_input_read = in_snap_reg & in_sel_reg.mask;
    logic [NIN-1:0] in_result_w;

    always_comb begin
        case (in_sel_reg.mode)
            PIOEP_SINGLE_READ: in_result_w = {{(NIN-1){1'b0}}, single_w};
            PIOEP_RANGE_READ: in_result_w = range_w;
            PIOEP_MASKED_INPUT_READ: in_result_w = masked_input_read;
            default: in_result_w = '0;
        endcase
    end

    // Output selection: contiguous range or twelve-bit mask.
    wire pioep_out_cmd_type out_cmd_w = hwdata;
    wire logic [11:0] out_span_w = pioep_span(out_cmd_w.first, out_cmd_w.last);
    wire logic [NOUT-1:0] out_sel_w = out_cmd_w.range_sel ? out_span_w : out_cmd_w.mask;
    wire logic tick_w = (presc_reg == TICK_CYCLES - 32'h1);
    logic [NOUT-1:0] out_next;
    logic [DELAY_W-1:0] timer_next [NOUT];

    for (genvar gi = 0; gi < NOUT; gi++) begin : g_out
        wire logic hit_w = out_wr_w && out_sel_w[gi];
        wire logic run_w = tick_w && (timer_reg[gi] != '0);
        // A delayed write that is rewritten restarts; a plain write cancels its timer.
        assign timer_next[gi] = hit_w ? out_delay_reg :
            (run_w ? timer_reg[gi] - DELAY_W'(1) : timer_reg[gi]);
        assign out_next[gi] = hit_w ? out_cmd_w.state :
            ((run_w && timer_reg[gi] == DELAY_W'(1)) ? ~out_line[gi] : out_line[gi]);

        timed_revert_a: assert property ((ce && !hit_w && run_w && timer_reg[gi] == DELAY_W'(1))
            |=> out_line[gi] != $past(out_line[gi]))
            else $error("Timed output did not invert at expiry.");
        hold_steady_a: assert property ((ce && !hit_w && timer_reg[gi] == '0)
            |=> $stable(out_line[gi]))
            else $error("Untimed output changed without a write.");
    end

    // Events: user trigger and rising edges on the external lines.
    wire logic trig_fire_w = (trig_reg == PIOEP_TRIG_ARMED) && !disarm_user_trigger;
    wire logic [NEDGE-1:0] edge_rise_w = edge_sync_w & ~edge_prev_reg;
    wire logic [NEVT-1:0] evt_w = {edge_rise_w, trig_fire_w};
    wire logic [NEVT-1:0] clr_w = wr_status_w ? hwdata[NEVT-1:0] : '0;
    // A new event wins over a clear in the same cycle.
    wire logic [NEVT-1:0] status_next = (status_reg & ~clr_w) | evt_w;

    always_comb begin
        case (trig_reg)
            PIOEP_TRIG_IDLE: trig_next = (arm_user_trigger && !disarm_user_trigger) ?
                PIOEP_TRIG_ARMED : PIOEP_TRIG_IDLE;
            PIOEP_TRIG_ARMED: trig_next = disarm_user_trigger ? PIOEP_TRIG_IDLE :
                PIOEP_TRIG_FIRED;
            PIOEP_TRIG_FIRED: trig_next = disarm_user_trigger ? PIOEP_TRIG_IDLE :
                PIOEP_TRIG_FIRED;
            default: trig_next = PIOEP_TRIG_IDLE;
        endcase
    end

    // Read data is chosen in the address phase so the slave never waits.
    logic [31:0] rdata_w;

    always_comb begin
        case (rd_addr_w)
            `PIOEP_ADDR_IN_LEVEL: rdata_w = 32'(in_snap_reg);
            `PIOEP_ADDR_IN_SEL: rdata_w = in_sel_reg;
            `PIOEP_ADDR_IN_RESULT: rdata_w = 32'(in_result_w);
            `PIOEP_ADDR_OUT_LEVEL: rdata_w = 32'(out_line);
            `PIOEP_ADDR_OUT_DELAY: rdata_w = 32'(out_delay_reg);
            `PIOEP_ADDR_TRIG_CTRL: rdata_w = {30'h0, trig_reg};
            `PIOEP_ADDR_STATUS: rdata_w = 32'(status_reg);
            `PIOEP_ADDR_MASK: rdata_w = 32'(mask_reg);
            `PIOEP_ADDR_EVT_LATCH0: rdata_w = 32'(latch_reg[0]);
            `PIOEP_ADDR_EVT_LATCH1: rdata_w = 32'(latch_reg[1]);
            `PIOEP_ADDR_EVT_LATCH2: rdata_w = 32'(latch_reg[2]);
            `PIOEP_ADDR_EVT_LATCH3: rdata_w = 32'(latch_reg[3]);
            default: rdata_w = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h00000000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else if (ce) begin
            wr_pend_reg <= wr_take_w;
            if (wr_take_w) begin
                wr_addr_reg <= rd_addr_w;
            end
            if (rd_take_w) begin
                hrdata <= rdata_w;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_sel_reg <= `PIOEP_IN_SEL_RESET;
            out_delay_reg <= `PIOEP_DELAY_RESET;
            mask_reg <= `PIOEP_MASK_RESET;
            status_reg <= '0;
            irq <= 1'b0;
            trig_reg <= PIOEP_TRIG_IDLE;
            presc_reg <= 32'h00000000;
            in_snap_reg <= '0;
            edge_prev_reg <= '0;
        end else if (ce) begin
            if (wr_in_sel_w) begin
                in_sel_reg <= hwdata;
            end
            if (wr_delay_w) begin
                out_delay_reg <= hwdata[DELAY_W-1:0];
            end
            if (wr_mask_w) begin
                mask_reg <= hwdata[NEVT-1:0];
            end
            status_reg <= status_next;
            irq <= |(status_next & mask_reg);
            trig_reg <= trig_next;
            presc_reg <= tick_w ? 32'h00000000 : presc_reg + 32'h1;
            in_snap_reg <= in_sync_w;
            edge_prev_reg <= edge_sync_w;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_line <= `PIOEP_OUT_RESET;
            timer_reg <= '{default: '0};
            latch_reg <= '{default: '0};
        end else if (ce) begin
            out_line <= out_next;
            timer_reg <= timer_next;
            for (int k = 0; k < NEVT; k++) begin
                if (evt_w[k]) begin
                    latch_reg[k] <= in_snap_reg;
                end
            end
        end
    end

    sequence write_taken_s;
        ce && out_wr_w && !tick_w;
    endsequence

    sequence trig_armed_s;
        ce && trig_fire_w;
    endsequence

    out_drive_a: assert property (write_taken_s |=>
        ((out_line & $past(out_sel_w)) == ({NOUT{$past(out_cmd_w.state)}} & $past(out_sel_w))))
        else $error("Selected output lines did not take the written state.");
    out_unsel_keep_a: assert property (write_taken_s |=>
        ((out_line & ~$past(out_sel_w)) == ($past(out_line) & ~$past(out_sel_w))))
        else $error("An unselected output line changed on a write.");
    mask_sel_a: assert property ((ce && out_wr_w && !out_cmd_w.range_sel) |=>
        ((out_line & $past(out_cmd_w.mask)) ==
        ({NOUT{$past(out_cmd_w.state)}} & $past(out_cmd_w.mask))))
        else $error("Masked output write selected the wrong lines.");
    // A disarm and a new arm can legally fire again three cycles later.
    trig_once_a: assert property (trig_armed_s |=> !trig_fire_w [*2])
        else $error("User trigger fired more than once.");
    trig_rearm_a: assert property ((ce && trig_reg == PIOEP_TRIG_FIRED && !disarm_user_trigger)
        |=> trig_reg == PIOEP_TRIG_FIRED)
        else $error("Fired trigger re-armed without a disarm.");
    edge_event_a: assert property ((ce && edge_rise_w[0]) |=> status_reg[`PIOEP_STAT_EDGE_LSB])
        else $error("Edge on line one raised no event.");
    latch_hold_a: assert property ((!(ce && evt_w[1])) |=> $stable(latch_reg[1]))
        else $error("Event latch changed without its event.");
    masked_read_a: assert property ((ce && rd_take_w && rd_addr_w == `PIOEP_ADDR_IN_RESULT &&
        in_sel_reg.mode == PIOEP_MASKED_INPUT_READ) |=>
        hrdata == 32'($past(in_snap_reg) & $past(in_sel_reg.mask)))
        else $error("Masked input read returned the wrong value.");
    range_read_a: assert property ((in_sel_reg.mode == PIOEP_RANGE_READ &&
        in_sel_reg.first == 3'h3 && in_sel_reg.last == 3'h5) |->
        in_result_w == (in_snap_reg & 5'h1C))
        else $error("Range read weighted the lines wrongly.");
    sync_delay_a: assert property (ce [*3] |-> in_snap_reg == $past(in_line_pin, 3))
        else $error("Input snapshot does not trail the pins by three edges.");
    tick_period_a: assert property ((ce && tick_w) |=> presc_reg == 32'h0)
        else $error("Prescaler did not restart after a tick.");

endmodule

`default_nettype wire

/* tb/pioep_ext_equip.sv */
// Model of the external equipment on the parallel connector.
// Assumes the bench commands the levels; pins move 1 ns later, off the clock edge.
`timescale 1ns/1ns
`default_nettype none

module pioep_ext_equip (
    input wire logic [4:0] in_cmd,
    input wire logic [2:0] edge_cmd,
    input wire logic [11:0] out_line,
    output wire logic [4:0] in_line_pin,
    output wire logic [2:0] ext_transition_pin,
    output wire logic [11:0] seen_out
);
    // The delay keeps pin changes asynchronous to the port clock.
    assign #1 in_line_pin = in_cmd;
    assign #1 ext_transition_pin = edge_cmd;
    assign seen_out = out_line;
endmodule

`default_nettype wire

/* tb/parallel_io_event_port_tb.sv */
// Self-checking bench for the parallel input/output event port.
// Assumes an AHB-Lite slave with zero wait states and a one-second tick of 8 cycles.
`timescale 1ns/1ns
`default_nettype none
`include "pioep_params.svh"

module parallel_io_event_port_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic ce = 1'b1;
    logic hsel = 1'b1;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    wire logic hready;
    logic hreadyout, hresp, irq;
    logic [31:0] hrdata, rd, w, me, mo;
    logic [11:0] out_line, seen_out, exp_out, m;
    wire logic [4:0] in_line_pin;
    wire logic [2:0] ext_pin;
    logic [4:0] in_cmd = 5'h0;
    logic [4:0] lv;
    logic [2:0] edge_cmd = 3'h0;
    logic s;
    logic [31:0] exp_q[$];
    logic [31:0] obs_q[$];
    int mismatches = 0;
    int checks = 0;
    int cyc = 0;
    int f, l;

    assign hready = hreadyout;

    pioep_top #(.TICK_CYCLES(32'h8)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .in_line_pin(in_line_pin), .ext_transition_pin(ext_pin),
        .out_line(out_line), .irq(irq));

    pioep_ext_equip i_equip (.in_cmd(in_cmd), .edge_cmd(edge_cmd), .out_line(out_line),
        .in_line_pin(in_line_pin), .ext_transition_pin(ext_pin), .seen_out(seen_out));

    always #2 hclk = ~hclk;

    // The monitor compares at the falling edge, when every result has settled.
    always @(negedge hclk) begin
        while (obs_q.size() > 0) begin
            me = exp_q.pop_front();
            mo = obs_q.pop_front();
            checks++;
            if (mo !== me) begin
                mismatches++;
                $display("Error at %0t: got %h expected %h", $time, mo, me);
            end
        end
    end

    task automatic report_and_stop;
        // The second falling edge lets the monitor take the last note first.
        repeat (2) @(negedge hclk);
        $display("Checks %0d, mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic note(input logic [31:0] e, input logic [31:0] o);
        exp_q.push_back(e);
        obs_q.push_back(o);
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    // The idle cycle after each write keeps a following read of the same place fresh.
    task automatic wr_reg(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
        @(posedge hclk);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        note(e, rd);
        note(32'h0, {31'h0, hresp});
    endtask

    task automatic irq_chk(input logic e);
        @(posedge hclk);
        note({31'h0, e}, {31'h0, irq});
    endtask

    task automatic pins(input logic [4:0] lvl, input logic [2:0] ed);
        in_cmd <= lvl;
        edge_cmd <= ed;
        repeat (6) @(posedge hclk);
    endtask

    task automatic out_chk;
        note({20'h0, exp_out}, {20'h0, seen_out});
        rd_chk(`PIOEP_ADDR_OUT_LEVEL, {20'h0, exp_out});
    endtask

    function automatic logic [31:0] isel(logic [1:0] md, int fi, int la, logic [4:0] k);
        return {14'h0, md, 1'b0, 3'(la), 1'b0, 3'(fi), 3'h0, k};
    endfunction

    function automatic logic [31:0] ocmd(logic [11:0] k, logic st, logic rg, int fi, int la);
        return {8'h0, 4'(la), 4'(fi), 2'h0, rg, st, k};
    endfunction

    initial begin
        void'($urandom(32'hC9EC));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`PIOEP_ADDR_OUT_LEVEL, 32'h0);
        rd_chk(`PIOEP_ADDR_OUT_DELAY, 32'h0);
        rd_chk(`PIOEP_ADDR_IN_SEL, 32'h0);
        rd_chk(`PIOEP_ADDR_MASK, 32'h0);
        rd_chk(`PIOEP_ADDR_STATUS, 32'h0);
        rd_chk(`PIOEP_ADDR_TRIG_CTRL, 32'h0);
        wr_reg(32'h40, 32'hFFFFFFFF);
        rd_chk(32'h40, 32'h0);
        for (int i = 0; i < 4; i++) begin
            lv = (i == 0) ? 5'h15 : 5'($urandom);
            pins(lv, 3'h0);
            rd_chk(`PIOEP_ADDR_IN_LEVEL, {27'h0, lv});
            for (int n = 1; n <= 5; n++) begin
                wr_reg(`PIOEP_ADDR_IN_SEL, isel(2'h0, n, n, 5'h0));
                rd_chk(`PIOEP_ADDR_IN_RESULT, {31'h0, lv[n-1]});
            end
            f = (i == 0) ? 3 : 1 + $urandom % 5;
            l = (i == 0) ? 5 : f + $urandom % (6 - f);
            w = ((32'h1 << l) - 32'h1) ^ ((32'h1 << (f - 1)) - 32'h1);
            wr_reg(`PIOEP_ADDR_IN_SEL, isel(2'h1, f, l, 5'h0));
            rd_chk(`PIOEP_ADDR_IN_RESULT, {27'h0, lv & w[4:0]});
            w = (i == 0) ? 32'h13 : 32'($urandom) & 32'h1F;
            wr_reg(`PIOEP_ADDR_IN_SEL, isel(2'h2, 1, 1, w[4:0]));
            rd_chk(`PIOEP_ADDR_IN_RESULT, {27'h0, lv & w[4:0]});
        end
        wr_reg(`PIOEP_ADDR_OUT_CMD, ocmd(12'h8D6, 1'b1, 1'b0, 0, 0));
        exp_out = 12'h8D6;
        out_chk();
        wr_reg(`PIOEP_ADDR_OUT_CMD, ocmd(12'h0, 1'b0, 1'b1, 3, 5));
        exp_out = exp_out & ~12'h01C;
        out_chk();
        for (int i = 0; i < 4; i++) begin
            m = 12'($urandom);
            s = 1'($urandom);
            wr_reg(`PIOEP_ADDR_OUT_CMD, ocmd(m, s, 1'b0, 0, 0));
            exp_out = s ? (exp_out | m) : (exp_out & ~m);
            out_chk();
        end
        repeat (40) @(posedge hclk);
        out_chk();
        wr_reg(`PIOEP_ADDR_OUT_DELAY, 32'h3);
        rd_chk(`PIOEP_ADDR_OUT_DELAY, 32'h3);
        wr_reg(`PIOEP_ADDR_OUT_CMD, ocmd(12'h801, 1'b1, 1'b0, 0, 0));
        exp_out = exp_out | 12'h801;
        repeat (10) @(posedge hclk);
        out_chk();
        repeat (20) @(posedge hclk);
        exp_out = exp_out & ~12'h801;
        out_chk();
        wr_reg(`PIOEP_ADDR_OUT_DELAY, 32'h0);
        pins(5'h0A, 3'h0);
        wr_reg(`PIOEP_ADDR_TRIG_CTRL, 32'h1);
        rd_chk(`PIOEP_ADDR_TRIG_CTRL, 32'(pioep_pkg::PIOEP_TRIG_FIRED));
        rd_chk(`PIOEP_ADDR_STATUS, 32'h1);
        rd_chk(`PIOEP_ADDR_EVT_LATCH0, 32'h0A);
        irq_chk(1'b0);
        wr_reg(`PIOEP_ADDR_MASK, 32'h1);
        irq_chk(1'b1);
        wr_reg(`PIOEP_ADDR_STATUS, 32'h1);
        rd_chk(`PIOEP_ADDR_STATUS, 32'h0);
        irq_chk(1'b0);
        pins(5'h11, 3'h0);
        wr_reg(`PIOEP_ADDR_TRIG_CTRL, 32'h1);
        rd_chk(`PIOEP_ADDR_STATUS, 32'h0);
        rd_chk(`PIOEP_ADDR_EVT_LATCH0, 32'h0A);
        wr_reg(`PIOEP_ADDR_TRIG_CTRL, 32'h2);
        rd_chk(`PIOEP_ADDR_TRIG_CTRL, 32'h0);
        wr_reg(`PIOEP_ADDR_TRIG_CTRL, 32'h1);
        rd_chk(`PIOEP_ADDR_STATUS, 32'h1);
        rd_chk(`PIOEP_ADDR_EVT_LATCH0, 32'h11);
        wr_reg(`PIOEP_ADDR_STATUS, 32'h1);
        wr_reg(`PIOEP_ADDR_MASK, 32'hE);
        for (int n = 0; n < 3; n++) begin
            lv = 5'($urandom);
            // Inputs settle before the edge so the event latches the new levels.
            pins(lv, 3'h0);
            pins(lv, 3'h1 << n);
            rd_chk(`PIOEP_ADDR_STATUS, 32'h2 << n);
            rd_chk(`PIOEP_ADDR_EVT_LATCH1 + 4 * n, {27'h0, lv});
            irq_chk(1'b1);
            wr_reg(`PIOEP_ADDR_STATUS, 32'h2 << n);
            pins(~lv, 3'h0);
            rd_chk(`PIOEP_ADDR_STATUS, 32'h0);
            rd_chk(`PIOEP_ADDR_EVT_LATCH1 + 4 * n, {27'h0, lv});
            irq_chk(1'b0);
        end
        report_and_stop();
    end
endmodule

`default_nettype wire
